/* shared/yls_params.svh */
`ifndef YLS_PARAMS_SVH
`define YLS_PARAMS_SVH
// Register indices; byte address is four times the index
`define YLS_IDX_FLAG      12'h9c0
`define YLS_IDX_RAW       12'h9c2
`define YLS_IDX_LIVE      12'h9c4
`define YLS_IDX_EN        12'h9c6
`define YLS_IDX_WIDTH     12'h9d0
`define YLS_IDX_BASE      12'h9d2
// Field positions
`define YLS_BIT_EMPTY     0
`define YLS_BIT_HALF      1
`define YLS_BIT_FULL      2
`define YLS_BIT_TERM      3
`define YLS_PIX_LSB       4
// Reset values
`define YLS_EN_RST        3'h0
`define YLS_WCODE_RST     3'h0
`define YLS_BASE_RST      7'h60
`define YLS_LIVE_RSVD     4'hf
// Level thresholds and codes
`define YLS_EMPTY_422     17'h00010
`define YLS_EMPTY_420     17'h00008
`define YLS_MODE_OFF      3'h0
`define YLS_MODE_DEC_OUT  3'h4
`define YLS_WCODE_MAX     3'h4
`define YLS_KB_SHIFT      10
`define YLS_TOP_ADDR      19'h4ffff
`endif

/* shared/yls_pkg.sv */
package yls_pkg;
    // One bit per level condition
    typedef struct packed {
        logic full;
        logic half;
        logic empty;
    } yls_lvl_t;

    // All state of the top module
    typedef struct packed {
        yls_lvl_t    flag;
        logic        term;
        yls_lvl_t    raw;
        yls_lvl_t    live;
        yls_lvl_t    en;
        logic [2:0]  wcode;
        logic [6:0]  base;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        irq;
        logic        port_rd;
        logic        st_valid;
        logic [15:0] st_data;
        logic        term_pulse;
    } yls_state_t;
endpackage

/* rtl/yls_width.sv */
`include "yls_params.svh"
// Decodes the width code into pixel count and buffer size
module yls_width (
    input  wire logic [2:0]  code,
    output logic      [10:0] pixels,
    output logic      [16:0] size_bytes,
    output logic             reserved
);
    logic [6:0] kbytes;

    // Width code table; codes above four are reserved and report zero size
    always_comb begin
        reserved = 1'b0;
        unique case (code)
            3'h0: begin pixels = 11'h280; kbytes = 7'h1e; end
            3'h1: begin pixels = 11'h320; kbytes = 7'h26; end
            3'h2: begin pixels = 11'h400; kbytes = 7'h30; end
            3'h3: begin pixels = 11'h500; kbytes = 7'h3c; end
            3'h4: begin pixels = 11'h640; kbytes = 7'h4b; end
            default: begin
                pixels   = 11'h000;
                kbytes   = 7'h00;
                reserved = 1'b1;
            end
        endcase
    end

    // Kilobytes to bytes
    assign size_bytes = {kbytes, 10'h000};
endmodule // yls_width

/* rtl/yls_level.sv */
`include "yls_params.svh"
// Level conditions from byte count; zero while the codec is off
module yls_level (
    input  wire logic [16:0]     level,
    input  wire logic [16:0]     size_bytes,
    input  wire logic            fmt_420,
    input  wire logic [2:0]      mode,
    output yls_pkg::yls_lvl_t    cond
);
    logic        active;
    logic [16:0] empty_lim;

    // Flags only mean something when a codec mode is selected
    assign active    = (mode != `YLS_MODE_OFF);
    assign empty_lim = fmt_420 ? `YLS_EMPTY_420 : `YLS_EMPTY_422;

    // Threshold compares
    always_comb begin
        cond.full  = active && (size_bytes != 17'h00000) && (level >= size_bytes);
        cond.half  = active && (level >= {1'b0, size_bytes[16:1]});
        cond.empty = active && (level <= empty_lim);
    end
endmodule // yls_level

/* rtl/yls_top.sv */
`include "yls_params.svh"
// What this block does
// - Empty means at most 16 bytes of 4:2:2 or 8 of 4:2:0
// - Raw full, half and empty set from level alone, ignoring enables
// - Level flags are valid only when codec mode is not zero
// - Writing 1 to a latched flag bit clears it
// - Latched full flag sets only while full enable is 1
// - Separate enables: full bit 2, half bit 1, empty bit 0
// - Read-only live status, unlatched and enable independent
// - Read-only field reports supported horizontal pixel width
// - Width codes map 640 to 1600 pixels; 101 to 111 reserved
// - Host write into a full buffer is dropped and recorded
// - Decoded output mode 100 turns the data port into a read port
module yls_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [13:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [2:0]  codec_mode,
    input  wire logic        fmt_420,
    input  wire logic [16:0] lb_level,
    input  wire logic        lb_wr_valid,
    input  wire logic [15:0] lb_wr_data,
    output logic             lb_store_valid,
    output logic      [15:0] lb_store_data,
    output logic             lb_wr_term,
    output logic             lb_port_rd,
    output logic      [18:0] lb_base_addr,
    output logic             lb_irq
);
    yls_pkg::yls_state_t st;
    yls_pkg::yls_state_t next_st;
    yls_pkg::yls_lvl_t   cond;
    logic [10:0]         pixels;
    logic [16:0]         size_bytes;
    logic                code_rsvd;
    logic                wr_rsvd;
    logic [11:0]         idx;
    logic                setup;
    logic                wr_do;
    logic                mapped;

    // Size decode from the stored width code
    yls_width u_width (
        .code       (st.wcode),
        .pixels     (pixels),
        .size_bytes (size_bytes),
        .reserved   (code_rsvd)
    );

    // Level compare
    yls_level u_level (
        .level      (lb_level),
        .size_bytes (size_bytes),
        .fmt_420    (fmt_420),
        .mode       (codec_mode),
        .cond       (cond)
    );

    // Reserved code on the write data, checked before it is stored
    yls_width u_wchk (
        .code       (pwdata[2:0]),
        .pixels     (),
        .size_bytes (),
        .reserved   (wr_rsvd)
    );

    // Bus decode
    assign idx    = paddr[13:2];
    assign setup  = psel && !penable;
    assign wr_do  = psel && penable && st.pready && pwrite && !st.pslverr;
    assign mapped = (paddr[1:0] == 2'h0) &&
                    (idx == `YLS_IDX_FLAG || idx == `YLS_IDX_RAW ||
                     idx == `YLS_IDX_LIVE || idx == `YLS_IDX_EN ||
                     idx == `YLS_IDX_WIDTH || idx == `YLS_IDX_BASE);

    // Next state
    always_comb begin
        next_st = st;
        // Zero-wait answer: ready in the first access cycle
        next_st.pready = setup;
        if (setup) begin
            next_st.pslverr = !mapped;
            next_st.prdata  = 32'h00000000;
            if (!pwrite) begin
                unique case (idx)
                    `YLS_IDX_FLAG:  next_st.prdata[3:0] = {st.term, st.flag};
                    `YLS_IDX_RAW:   next_st.prdata[2:0] = st.raw;
                    // Upper nibble reads as ones; live bits unlatched
                    `YLS_IDX_LIVE:  next_st.prdata[15:0] =
                                        {`YLS_LIVE_RSVD, 9'h000, st.live};
                    `YLS_IDX_EN:    next_st.prdata[2:0] = st.en;
                    `YLS_IDX_WIDTH: next_st.prdata[14:0] =
                                        {pixels, 1'b0, st.wcode};
                    `YLS_IDX_BASE:  next_st.prdata[6:0] = st.base;
                    default:        next_st.prdata = 32'h00000000;
                endcase
            end
        end

        // Live copy sees only the level, never the enables
        next_st.live = cond;
        // Register writes; the flag write is write-one-to-clear
        if (wr_do && pstrb[0]) begin
            unique case (idx)
                `YLS_IDX_FLAG: begin
                    next_st.flag = st.flag & ~yls_pkg::yls_lvl_t'(pwdata[2:0]);
                    next_st.raw  = st.raw  & ~yls_pkg::yls_lvl_t'(pwdata[2:0]);
                    if (pwdata[`YLS_BIT_TERM]) begin
                        next_st.term = 1'b0;
                    end
                end
                `YLS_IDX_EN:    next_st.en = yls_pkg::yls_lvl_t'(pwdata[2:0]);
                // Reserved codes are refused and the old size kept
                `YLS_IDX_WIDTH: if (!wr_rsvd) begin
                    next_st.wcode = pwdata[2:0];
                end
                `YLS_IDX_BASE:  next_st.base = pwdata[6:0];
                default: ;
            endcase
        end
        // Set wins over a clear in the same cycle
        next_st.raw  = next_st.raw | cond;
        next_st.flag = next_st.flag | (cond & st.en);

        // Host write port: drop writes while full and record it
        next_st.st_valid   = lb_wr_valid && !cond.full && !st.port_rd;
        next_st.term_pulse = lb_wr_valid && cond.full && !st.port_rd;
        if (lb_wr_valid) begin
            next_st.st_data = lb_wr_data;
        end
        if (next_st.term_pulse) begin
            next_st.term = 1'b1;
        end

        // Decoded output to host turns the port around
        next_st.port_rd = (codec_mode == `YLS_MODE_DEC_OUT);
        // Enabled latched flags reach the interrupt tree
        next_st.irq = |(next_st.flag & st.en);
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st       <= '0;
            st.en    <= `YLS_EN_RST;
            st.wcode <= `YLS_WCODE_RST;
            st.base  <= `YLS_BASE_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign prdata         = st.prdata;
    assign pready         = st.pready;
    assign pslverr        = st.pslverr;
    assign lb_store_valid = st.st_valid;
    assign lb_store_data  = st.st_data;
    assign lb_wr_term     = st.term_pulse;
    assign lb_port_rd     = st.port_rd;
    assign lb_base_addr   = {12'h000, st.base} << `YLS_KB_SHIFT;
    assign lb_irq         = st.irq;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_full_write;
        lb_wr_valid && cond.full && !lb_port_rd;
    endsequence

    sequence s_dropped;
        lb_wr_term && !lb_store_valid ##1 st.term;
    endsequence

    property p_empty_limit;
        (codec_mode != `YLS_MODE_OFF) && !fmt_420 && (lb_level <= `YLS_EMPTY_422)
            |=> st.live.empty && st.raw.empty;
    endproperty
    a_empty_limit: assert property (p_empty_limit) else $error("empty not seen");

    property p_raw_no_enable;
        cond.full && !st.en.full |=> st.raw.full && !($rose(st.flag.full));
    endproperty
    a_raw_no_enable: assert property (p_raw_no_enable) else $error("raw full");

    property p_off_quiet;
        (codec_mode == `YLS_MODE_OFF) [*2] |-> st.live == 3'h0;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("flags while off");

    property p_w1c;
        wr_do && pstrb[0] && idx == `YLS_IDX_FLAG && pwdata[0] && !cond.empty
            |=> !st.flag.empty;
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag not cleared");

    property p_full_latch;
        $rose(st.flag.full) |-> $past(st.en.full) && $past(cond.full);
    endproperty
    a_full_latch: assert property (p_full_latch) else $error("bad full latch");

    property p_enable_write;
        wr_do && pstrb[0] && idx == `YLS_IDX_EN |=> st.en == $past(pwdata[2:0]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable lost");

    property p_width_kept;
        !code_rsvd;
    endproperty
    a_width_kept: assert property (p_width_kept) else $error("reserved width");

    property p_term;
        s_full_write |=> s_dropped;
    endproperty
    a_term: assert property (p_term) else $error("full write stored");

    property p_port_dir;
        codec_mode == `YLS_MODE_DEC_OUT |=> lb_port_rd ##1 !lb_store_valid;
    endproperty
    a_port_dir: assert property (p_port_dir) else $error("port not read");

    property p_irq;
        ##1 lb_irq == |(st.flag & $past(st.en));
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");
endmodule // yls_top

/* sim/yls_host_port.sv */
// Host side of the line buffer data port
module yls_host_port (
    input  wire logic        pclk,
    input  wire logic        store_valid,
    input  wire logic        wr_term,
    output logic             wr_valid,
    output logic      [15:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // Port idle at time zero
    initial begin
        wr_valid = 1'b0;
        wr_data  = 16'h0000;
    end

    // One write pulse; the answer is taken one edge after acceptance
    task automatic push(input logic [15:0] d, output logic st, output logic tm);
        @(posedge pclk);
        wr_valid <= 1'b1;
        wr_data  <= d;
        @(posedge pclk);
        wr_valid <= 1'b0;
        wr_data  <= ~d; // Released lines must not look like held data
        @(posedge pclk);
        st = store_valid;
        tm = wr_term;
    endtask
endmodule // yls_host_port

/* sim/yls_top_tb.sv */
`include "yls_params.svh"
// Self-checking bench for the line buffer status block
module yls_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [13:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  strb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  mode;
    logic        fmt;
    logic [16:0] lvl;
    logic        wr_valid;
    logic [15:0] wr_data;
    logic        st_v;
    logic [15:0] st_d;
    logic        term;
    logic        port_rd;
    logic [18:0] base;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    logic        st;
    logic        tm;
    int          error_cnt;
    int          n_tests;

    yls_top yls_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .codec_mode(mode), .fmt_420(fmt),
        .lb_level(lvl), .lb_wr_valid(wr_valid), .lb_wr_data(wr_data),
        .lb_store_valid(st_v), .lb_store_data(st_d), .lb_wr_term(term),
        .lb_port_rd(port_rd), .lb_base_addr(base), .lb_irq(irq));
    yls_host_port yls_host_port_i (.pclk(pclk), .store_valid(st_v), .wr_term(term),
        .wr_valid(wr_valid), .wr_data(wr_data));

    // 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            $display("wrong value pready expected 1 seen timeout");
            results();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] idx, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, idx, 32'h0);
        chk($sformatf("reg %h", idx), e, rd & m);
    endtask

    task automatic setlv(input logic [2:0] md, input logic f, input logic [16:0] l);
        @(posedge pclk);
        mode <= md;
        fmt  <= f;
        lvl  <= l;
        repeat (3) @(posedge pclk);
    endtask

    // Reset values of the enable, width, base and live registers
    task automatic t_reset();
        rchk(`YLS_IDX_EN, 32'hffffffff, 32'h00000000);
        rchk(`YLS_IDX_WIDTH, 32'hffffffff, 32'h00002800);
        rchk(`YLS_IDX_BASE, 32'hffffffff, 32'h00000060);
        rchk(`YLS_IDX_LIVE, 32'hffffffff, 32'h0000f000);
        chk("base", 32'h00018000, {13'h0, base});
        $display("test reset done");
    endtask

    // Every width code, then a reserved code that must be ignored
    task automatic t_width();
        logic [10:0] pix [5] = '{11'd640, 11'd800, 11'd1024, 11'd1280, 11'd1600};
        for (int c = 0; c < 5; c++) begin
            apb(1'b1, `YLS_IDX_WIDTH, 32'(c));
            rchk(`YLS_IDX_WIDTH, 32'hffffffff, {17'h0, pix[c], 1'b0, 3'(c)});
        end
        apb(1'b1, `YLS_IDX_WIDTH, 32'h00000005);
        rchk(`YLS_IDX_WIDTH, 32'hffffffff, 32'h00006404);
        $display("test width done");
    endtask

    // Live conditions at the threshold edges; size is 76800 bytes now
    task automatic t_level();
        setlv(3'h1, 1'b0, 17'h00010);
        rchk(`YLS_IDX_LIVE, 32'hffffffff, 32'h0000f001);
        setlv(3'h1, 1'b0, 17'h00011);
        rchk(`YLS_IDX_LIVE, 32'hffffffff, 32'h0000f000);
        setlv(3'h1, 1'b1, 17'h00008);
        rchk(`YLS_IDX_LIVE, 32'hffffffff, 32'h0000f001);
        setlv(3'h1, 1'b1, 17'h00009);
        rchk(`YLS_IDX_LIVE, 32'hffffffff, 32'h0000f000);
        setlv(3'h1, 1'b0, 17'h12bff);
        rchk(`YLS_IDX_LIVE, 32'hffffffff, 32'h0000f002);
        setlv(3'h1, 1'b0, 17'h12c00);
        rchk(`YLS_IDX_LIVE, 32'hffffffff, 32'h0000f006);
        rchk(`YLS_IDX_FLAG, 32'h00000007, 32'h00000000);
        rchk(`YLS_IDX_RAW, 32'h00000006, 32'h00000006);
        setlv(3'h0, 1'b0, 17'h12c00);
        rchk(`YLS_IDX_LIVE, 32'hffffffff, 32'h0000f000);
        $display("test level done");
    endtask

    // One enable at a time: latch, interrupt, set-wins clear, real clear
    task automatic t_flags();
        logic [16:0] lv [3] = '{17'h00010, 17'h09600, 17'h12c00};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `YLS_IDX_EN, 32'(1 << i));
            setlv(3'h1, 1'b0, lv[i]);
            rchk(`YLS_IDX_FLAG, 32'h00000007, 32'(1 << i));
            chk("irq", 32'h00000001, {31'h0, irq});
            apb(1'b1, `YLS_IDX_FLAG, 32'h00000007);
            rchk(`YLS_IDX_FLAG, 32'h00000007, 32'(1 << i));
            setlv(3'h1, 1'b0, 17'h00064);
            apb(1'b1, `YLS_IDX_FLAG, 32'h00000007);
            rchk(`YLS_IDX_FLAG, 32'h00000007, 32'h00000000);
            rchk(`YLS_IDX_RAW, 32'h00000007, 32'h00000000);
            chk("irq", 32'h00000000, {31'h0, irq});
        end
        apb(1'b1, `YLS_IDX_EN, 32'h00000000);
        $display("test flags done");
    endtask

    // Data port: dropped write, stored write, read-port mode
    task automatic t_port();
        setlv(3'h1, 1'b0, 17'h12c00);
        yls_host_port_i.push(16'h1234, st, tm);
        chk("term", 32'h00000001, {30'h0, st, tm});
        rchk(`YLS_IDX_FLAG, 32'h00000008, 32'h00000008);
        apb(1'b1, `YLS_IDX_FLAG, 32'h00000008);
        rchk(`YLS_IDX_FLAG, 32'h00000008, 32'h00000000);
        setlv(3'h1, 1'b0, 17'h00064);
        yls_host_port_i.push(16'h5a3c, st, tm);
        chk("store", 32'h00025a3c, {14'h0, st, tm, st_d});
        setlv(3'h4, 1'b0, 17'h00064);
        yls_host_port_i.push(16'h0ff0, st, tm);
        chk("read port", 32'h00000004, {29'h0, port_rd, st, tm});
        $display("test port done");
    endtask

    // Base offset and a reserved slot, read only
    task automatic t_misc();
        apb(1'b1, `YLS_IDX_BASE, 32'h00000035);
        rchk(`YLS_IDX_BASE, 32'hffffffff, 32'h00000035);
        // A write without the low byte strobe must leave the offset alone
        strb <= 4'h0;
        apb(1'b1, `YLS_IDX_BASE, 32'h00000012);
        strb <= 4'hf;
        rchk(`YLS_IDX_BASE, 32'hffffffff, 32'h00000035);
        chk("base", 32'h0000d400, {13'h0, base});
        rchk(12'h9c8, 32'hffffffff, 32'h00000000);
        chk("slverr", 32'h00000001, {31'h0, err});
        $display("test misc done");
    endtask

    // Main sequence
    initial begin
        error_cnt = 0;
        n_tests = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 14'h0000;
        pwdata = 32'h00000000;
        strb = 4'hf;
        mode = 3'h0;
        fmt = 1'b0;
        lvl = 17'h00000;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_width();
        t_level();
        t_flags();
        t_port();
        t_misc();
        results();
    end
endmodule // yls_top_tb
